// file: src/lmps_regs.vh
// register map, field positions, reset values and timing of the list sequencer
// Notes on behaviour
// - up runs first to last, down reversed; up default
// - first dwell value sets global dwell, rest ignored
// - dwell count query returns dwell entries held
// - frequency points stored in the order written
// - frequency count query returns stored frequency points
// - power points stored in the order written
// - power count query returns stored power points
// - convert query converts raw list, answers zero
// - repeat style sweep, step or continuous, readable
// - subset indexes pick points, run in given order
// - subset count query returns index entries held
// - auto on runs all points; off runs subset
// - auto command also switches into list mode
// - marker select: none, first, last, every point
// - trigger starts one cycle, or one point in step; idle unless continuous
`ifndef LMPS_REGS_VH
`define LMPS_REGS_VH

// ******************************
// register byte offsets
// ******************************
`define LMPS_ADDR_W 8
`define LMPS_OFF_CTRL 8'h00
`define LMPS_OFF_AUTO 8'h04
`define LMPS_OFF_DWELL 8'h08
`define LMPS_OFF_FREQ 8'h0C
`define LMPS_OFF_POWER 8'h10
`define LMPS_OFF_SEQ 8'h14
`define LMPS_OFF_DWELL_CNT 8'h18
`define LMPS_OFF_FREQ_CNT 8'h1C
`define LMPS_OFF_POWER_CNT 8'h20
`define LMPS_OFF_SEQ_CNT 8'h24
`define LMPS_OFF_CMD 8'h28
`define LMPS_OFF_CONVERT 8'h2C
`define LMPS_OFF_STATUS 8'h30

// ******************************
// field positions
// ******************************
`define LMPS_CTRL_DIR 0
`define LMPS_CTRL_REP_LO 2
`define LMPS_CTRL_REP_HI 3
`define LMPS_CTRL_SYNC_LO 4
`define LMPS_CTRL_SYNC_HI 5
`define LMPS_CMD_TRIG 0
`define LMPS_CMD_CLEAR 1
`define LMPS_CMD_CONVERT 2
`define LMPS_CMD_ABORT 3
`define LMPS_CMD_LEAVE 4

// ******************************
// encodings and reset values
// ******************************
`define LMPS_DIR_UP 1'b0
`define LMPS_REP_SWEEP 2'h0
`define LMPS_REP_STEP 2'h1
`define LMPS_REP_CONT 2'h2
`define LMPS_SYNC_NONE 2'h0
`define LMPS_SYNC_FIRST 2'h1
`define LMPS_SYNC_LAST 2'h2
`define LMPS_SYNC_ALL 2'h3
`define LMPS_AUTO_RST 1'b1
`define LMPS_DWELL_RST 16'h0001
`define LMPS_RESP_OKAY 2'h0
`define LMPS_RESP_SLVERR 2'h2

// ******************************
// list sizes and timing
// ******************************
`define LMPS_IDX_W 4
`define LMPS_DEPTH 5'h10
`define LMPS_FREQ_W 32
`define LMPS_POWER_W 16
`define LMPS_CLK_PERIOD_NS 100
`define LMPS_DWELL_UNIT_NS 1000
`define LMPS_DWELL_CYC (`LMPS_DWELL_UNIT_NS / `LMPS_CLK_PERIOD_NS)

`endif

// file: src/lmps_list_mem.v
// small list memory with registered read data
`timescale 1ns/1ns
module lmps_list_mem #(
   parameter W = 32,
   parameter AW = 4
)(
   // clock
   input wire clk,
   // write port
   input wire wr_en,
   input wire [AW-1:0] wr_addr,
   input wire [W-1:0] wr_data,
   // read port
   input wire [AW-1:0] rd_addr,
   output reg [W-1:0] rd_data
);
   reg [W-1:0] mem [0:(1<<AW)-1];

   // one write and one registered read per cycle
   always @(posedge clk)
   begin
      if (wr_en)
         mem[wr_addr] <= wr_data;
      rd_data <= mem[rd_addr];
   end
endmodule // lmps_list_mem

// file: src/lmps_seq.v
// list mode point sequencer with axi4-lite register access
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
`include "lmps_regs.vh"
module lmps_seq (
   // clock and reset
   input wire ref_clk,
   input wire reset_n,
   // axi4-lite write address and data
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [`LMPS_ADDR_W-1:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   // axi4-lite write response
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   output wire [1:0] s_axi_bresp,
   // axi4-lite read
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   input wire [`LMPS_ADDR_W-1:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   // point outputs
   output reg [`LMPS_FREQ_W-1:0] out_freq,
   output reg [`LMPS_POWER_W-1:0] out_power,
   output reg sync_out,
   output reg list_mode,
   output wire run_busy
);
   localparam S_IDLE = 3'h0;
   localparam S_IDX = 3'h1;
   localparam S_PT = 3'h2;
   localparam S_PW = 3'h3;
   localparam S_LOAD = 3'h4;
   localparam S_DWELL = 3'h5;
   localparam C_IDLE = 2'h0;
   localparam C_RD = 2'h1;
   localparam C_WR = 2'h2;

   // ******************************
   // address decode
   // ******************************
   function mapped;
      input [`LMPS_ADDR_W-1:0] a;
      begin
         mapped = (a <= `LMPS_OFF_STATUS) && (a[1:0] == 2'h0);
      end
   endfunction

   // ******************************
   // reset release
   // ******************************
   reg rst_meta_reg;
   reg rst_n_reg;

   // async assert, two flops to release cleanly
   always @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rst_meta_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_n_reg <= rst_meta_reg;
      end
   end

   // ******************************
   // state declarations
   // ******************************
   reg aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg, rd_pend_reg;
   reg [`LMPS_ADDR_W-1:0] aw_addr_reg;
   reg [31:0] w_data_reg, rdata_reg;
   reg [3:0] w_strb_reg;
   reg [1:0] bresp_reg, rresp_reg;
   reg dir_reg, auto_reg;
   reg [1:0] rep_reg, sync_sel_reg;
   reg [15:0] dwell_reg;
   reg [4:0] dwell_cnt_reg, freq_cnt_reg, pow_cnt_reg, seq_cnt_reg;
   reg [2:0] state_reg;
   reg [4:0] step_reg;
   reg [`LMPS_IDX_W-1:0] pt_reg;
   reg [23:0] hold_reg;
   reg [1:0] conv_state_reg;
   reg [4:0] conv_idx_reg;
   reg [31:0] rd_mux;
   wire [`LMPS_FREQ_W-1:0] raw_freq;
   wire [`LMPS_POWER_W-1:0] raw_pow;
   wire [`LMPS_IDX_W-1:0] seq_idx;
   wire [47:0] proc_pt;

   // ******************************
   // axi4-lite slave
   // ******************************
   wire wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
   wire wr_ok = wr_fire && mapped(aw_addr_reg) && (w_strb_reg != 4'h0);
   wire rd_take = s_axi_arvalid && s_axi_arready;
   wire rd_conv = rd_take && (s_axi_araddr == `LMPS_OFF_CONVERT);
   wire conv_busy = (conv_state_reg != C_IDLE);

   assign s_axi_awready = !aw_held_reg && !bvalid_reg;
   assign s_axi_wready = !w_held_reg && !bvalid_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = !rvalid_reg && !rd_pend_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   // per-register write strobes, decoded once
   wire wr_ctrl = wr_ok && (aw_addr_reg == `LMPS_OFF_CTRL);
   wire wr_auto = wr_ok && (aw_addr_reg == `LMPS_OFF_AUTO);
   wire wr_dwell = wr_ok && (aw_addr_reg == `LMPS_OFF_DWELL);
   wire wr_freq = wr_ok && (aw_addr_reg == `LMPS_OFF_FREQ);
   wire wr_pow = wr_ok && (aw_addr_reg == `LMPS_OFF_POWER);
   wire wr_seq = wr_ok && (aw_addr_reg == `LMPS_OFF_SEQ);
   wire wr_cmd = wr_ok && (aw_addr_reg == `LMPS_OFF_CMD);
   wire cmd_trig = wr_cmd && w_data_reg[`LMPS_CMD_TRIG];
   wire cmd_clear = wr_cmd && w_data_reg[`LMPS_CMD_CLEAR];
   wire cmd_abort = wr_cmd && w_data_reg[`LMPS_CMD_ABORT];
   wire cmd_leave = wr_cmd && w_data_reg[`LMPS_CMD_LEAVE];
   wire conv_start = !conv_busy
      && (rd_conv || (wr_cmd && w_data_reg[`LMPS_CMD_CONVERT]));

   // write channel capture and response
   always @(posedge ref_clk or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         aw_addr_reg <= {`LMPS_ADDR_W{1'b0}};
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
         bresp_reg <= `LMPS_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_fire)
         begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= mapped(aw_addr_reg) ? `LMPS_RESP_OKAY
               : `LMPS_RESP_SLVERR;
         end
         else if (bvalid_reg && s_axi_bready)
            bvalid_reg <= 1'b0;
      end
   end

   // read data mux; frequency, power and subset list words are write only and read zero
   always @*
   begin
      rd_mux = 32'h00000000;
      case (s_axi_araddr)
         `LMPS_OFF_CTRL: rd_mux = {26'h0000000, sync_sel_reg, rep_reg,
            1'b0, dir_reg};
         `LMPS_OFF_AUTO: rd_mux = {31'h00000000, auto_reg};
         `LMPS_OFF_DWELL: rd_mux = {16'h0000, dwell_reg};
         `LMPS_OFF_DWELL_CNT: rd_mux = {27'h0000000, dwell_cnt_reg};
         `LMPS_OFF_FREQ_CNT: rd_mux = {27'h0000000, freq_cnt_reg};
         `LMPS_OFF_POWER_CNT: rd_mux = {27'h0000000, pow_cnt_reg};
         `LMPS_OFF_SEQ_CNT: rd_mux = {27'h0000000, seq_cnt_reg};
         `LMPS_OFF_STATUS: rd_mux = {28'h0000000, sync_out, conv_busy,
            run_busy, list_mode};
         default: rd_mux = 32'h00000000;
      endcase
   end

   // read answer; the convert query is held until conversion ends
   always @(posedge ref_clk or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         rvalid_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         rresp_reg <= `LMPS_RESP_OKAY;
      end
      else if (rd_conv)
         rd_pend_reg <= 1'b1;
      else if (rd_take)
      begin
         rvalid_reg <= 1'b1;
         rdata_reg <= rd_mux;
         rresp_reg <= mapped(s_axi_araddr) ? `LMPS_RESP_OKAY
            : `LMPS_RESP_SLVERR;
      end
      else if (rd_pend_reg && !conv_busy)
      begin
         rd_pend_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rdata_reg <= 32'h00000000;
         rresp_reg <= `LMPS_RESP_OKAY;
      end
      else if (rvalid_reg && s_axi_rready)
         rvalid_reg <= 1'b0;
   end

   // ******************************
   // settings and list storage
   // ******************************
   // appends beyond the depth are dropped, counts saturate
   always @(posedge ref_clk or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         dir_reg <= `LMPS_DIR_UP;
         rep_reg <= `LMPS_REP_SWEEP;
         sync_sel_reg <= `LMPS_SYNC_NONE;
         auto_reg <= `LMPS_AUTO_RST;
         list_mode <= 1'b0;
         dwell_reg <= `LMPS_DWELL_RST;
         dwell_cnt_reg <= 5'h00;
         freq_cnt_reg <= 5'h00;
         pow_cnt_reg <= 5'h00;
         seq_cnt_reg <= 5'h00;
      end
      else
      begin
         if (wr_ctrl && w_strb_reg[0])
         begin
            dir_reg <= w_data_reg[`LMPS_CTRL_DIR];
            if (w_data_reg[`LMPS_CTRL_REP_HI:`LMPS_CTRL_REP_LO] != 2'h3)
               rep_reg <= w_data_reg[`LMPS_CTRL_REP_HI:`LMPS_CTRL_REP_LO];
            sync_sel_reg <= w_data_reg[`LMPS_CTRL_SYNC_HI:`LMPS_CTRL_SYNC_LO];
         end
         if (wr_auto)
         begin
            auto_reg <= w_data_reg[0];
            list_mode <= 1'b1;
         end
         else if (cmd_leave)
            list_mode <= 1'b0;
         if (cmd_clear)
         begin
            dwell_cnt_reg <= 5'h00;
            freq_cnt_reg <= 5'h00;
            pow_cnt_reg <= 5'h00;
            seq_cnt_reg <= 5'h00;
         end
         else
         begin
            if (wr_dwell && dwell_cnt_reg == 5'h00)
               dwell_reg <= w_data_reg[15:0];
            if (wr_dwell && dwell_cnt_reg != `LMPS_DEPTH)
               dwell_cnt_reg <= dwell_cnt_reg + 5'h01;
            if (wr_freq && freq_cnt_reg != `LMPS_DEPTH)
               freq_cnt_reg <= freq_cnt_reg + 5'h01;
            if (wr_pow && pow_cnt_reg != `LMPS_DEPTH)
               pow_cnt_reg <= pow_cnt_reg + 5'h01;
            if (wr_seq && seq_cnt_reg != `LMPS_DEPTH)
               seq_cnt_reg <= seq_cnt_reg + 5'h01;
         end
      end
   end

   // raw lists, subset indexes and converted points
   lmps_list_mem #(.W(`LMPS_FREQ_W), .AW(`LMPS_IDX_W)) u_freq (
      .clk(ref_clk),
      .wr_en(wr_freq && freq_cnt_reg != `LMPS_DEPTH),
      .wr_addr(freq_cnt_reg[3:0]),
      .wr_data(w_data_reg),
      .rd_addr(conv_idx_reg[3:0]),
      .rd_data(raw_freq)
   );
   lmps_list_mem #(.W(`LMPS_POWER_W), .AW(`LMPS_IDX_W)) u_pow (
      .clk(ref_clk),
      .wr_en(wr_pow && pow_cnt_reg != `LMPS_DEPTH),
      .wr_addr(pow_cnt_reg[3:0]),
      .wr_data(w_data_reg[15:0]),
      .rd_addr(conv_idx_reg[3:0]),
      .rd_data(raw_pow)
   );
   wire [4:0] run_len = auto_reg ? freq_cnt_reg : seq_cnt_reg;
   wire [4:0] last_pos = run_len - 5'h01;
   wire [4:0] pos = dir_reg ? (last_pos - step_reg) : step_reg;
   lmps_list_mem #(.W(`LMPS_IDX_W), .AW(`LMPS_IDX_W)) u_seq (
      .clk(ref_clk),
      .wr_en(wr_seq && seq_cnt_reg != `LMPS_DEPTH),
      .wr_addr(seq_cnt_reg[3:0]),
      .wr_data(w_data_reg[3:0]),
      .rd_addr(pos[3:0]),
      .rd_data(seq_idx)
   );
   lmps_list_mem #(.W(48), .AW(`LMPS_IDX_W)) u_proc (
      .clk(ref_clk),
      .wr_en(conv_state_reg == C_WR),
      .wr_addr(conv_idx_reg[3:0]),
      .wr_data({(conv_idx_reg < pow_cnt_reg) ? raw_pow : 16'h0000,
         raw_freq}),
      .rd_addr(pt_reg),
      .rd_data(proc_pt)
   );

   // ******************************
   // list conversion
   // ******************************
   // walks the raw lists once, packing each point for the sequencer
   always @(posedge ref_clk or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         conv_state_reg <= C_IDLE;
         conv_idx_reg <= 5'h00;
      end
      else
         case (conv_state_reg)
            C_IDLE:
               if (conv_start)
               begin
                  conv_idx_reg <= 5'h00;
                  conv_state_reg <= (freq_cnt_reg == 5'h00) ? C_IDLE : C_RD;
               end
            C_RD: conv_state_reg <= C_WR;
            C_WR:
               if (conv_idx_reg + 5'h01 >= freq_cnt_reg)
                  conv_state_reg <= C_IDLE;
               else
               begin
                  conv_idx_reg <= conv_idx_reg + 5'h01;
                  conv_state_reg <= C_RD;
               end
            default: conv_state_reg <= C_IDLE;
         endcase
   end

   // ******************************
   // point sequencer
   // ******************************
   wire [31:0] dwell_prod = {16'h0000, dwell_reg} * `LMPS_DWELL_CYC;
   wire [23:0] dwell_cyc = dwell_prod[23:0];
   wire is_last = (step_reg == last_pos);
   wire mark = (sync_sel_reg == `LMPS_SYNC_ALL)
      || (sync_sel_reg == `LMPS_SYNC_FIRST && step_reg == 5'h00)
      || (sync_sel_reg == `LMPS_SYNC_LAST && is_last);
   assign run_busy = (state_reg != S_IDLE);

   // fetch index, fetch point, load outputs, dwell, advance
   always @(posedge ref_clk or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         state_reg <= S_IDLE;
         step_reg <= 5'h00;
         pt_reg <= {`LMPS_IDX_W{1'b0}};
         hold_reg <= 24'h000000;
         out_freq <= {`LMPS_FREQ_W{1'b0}};
         out_power <= {`LMPS_POWER_W{1'b0}};
         sync_out <= 1'b0;
      end
      else if (cmd_abort || !list_mode)
      begin
         state_reg <= S_IDLE;
         sync_out <= 1'b0;
      end
      else
         case (state_reg)
            S_IDLE:
               if (cmd_trig && run_len != 5'h00)
               begin
                  if (rep_reg != `LMPS_REP_STEP || step_reg >= run_len)
                     step_reg <= 5'h00;
                  state_reg <= S_IDX;
               end
            S_IDX: state_reg <= S_PT;
            S_PT:
            begin
               pt_reg <= auto_reg ? pos[3:0] : seq_idx;
               state_reg <= S_PW;
            end
            S_PW: state_reg <= S_LOAD;
            S_LOAD:
            begin
               out_freq <= proc_pt[31:0];
               out_power <= proc_pt[47:32];
               sync_out <= mark;
               hold_reg <= (dwell_cyc == 24'h000000) ? 24'h000000
                  : dwell_cyc - 24'h000001;
               state_reg <= S_DWELL;
            end
            S_DWELL:
               if (hold_reg != 24'h000000)
                  hold_reg <= hold_reg - 24'h000001;
               else
               begin
                  sync_out <= 1'b0;
                  step_reg <= is_last ? 5'h00 : step_reg + 5'h01;
                  if (rep_reg == `LMPS_REP_STEP)
                     state_reg <= S_IDLE;
                  else if (is_last && rep_reg != `LMPS_REP_CONT)
                     state_reg <= S_IDLE;
                  else
                     state_reg <= S_IDX;
               end
            default: state_reg <= S_IDLE;
         endcase
   end
endmodule // lmps_seq

// file: bench/lmps_seq_checker.sv
// port assertions for the list sequencer
`timescale 1ns/1ns
`include "lmps_regs.vh"
module lmps_seq_checker (
   // clock and reset
   input wire ref_clk,
   input wire reset_n,
   // bus handshakes
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [`LMPS_ADDR_W-1:0] s_axi_araddr,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [31:0] s_axi_rdata,
   // point outputs
   input wire [`LMPS_FREQ_W-1:0] out_freq,
   input wire sync_out,
   input wire run_busy
);
   // *****
   // properties
   // *****
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // both write channels taken at one edge
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // plain read taken; convert answers late
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready && s_axi_araddr != `LMPS_OFF_CONVERT;
   endsequence
   AST_WR_RESP: assert property (wr_taken |-> ##2 s_axi_bvalid)
      else $error("write response not on time");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   AST_RD_RESP: assert property (rd_taken |=> s_axi_rvalid)
      else $error("read answer not on time");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   AST_RD_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken during answer");
   AST_SYNC_RUN: assert property (sync_out |-> run_busy)
      else $error("marker high while idle");
   AST_SYNC_FALL: assert property ($fell(sync_out) |-> $stable(out_freq))
      else $error("marker fell with point change");
   AST_DWELL: assert property ($changed(out_freq) && run_busy |=>
      $stable(out_freq) [*8])
      else $error("point shorter than dwell");
endmodule // lmps_seq_checker

bind lmps_seq lmps_seq_checker u_chk (
   .ref_clk(ref_clk),
   .reset_n(reset_n),
   .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready),
   .s_axi_bresp(s_axi_bresp),
   .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready),
   .s_axi_araddr(s_axi_araddr),
   .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready),
   .s_axi_rdata(s_axi_rdata),
   .out_freq(out_freq),
   .sync_out(sync_out),
   .run_busy(run_busy)
);

// file: bench/lmps_host.sv
// host model: bus master issuing list commands and queries
`timescale 1ns/1ns
module lmps_host (
   // clock
   input wire ref_clk,
   // write side
   output reg awvalid,
   input wire awready,
   output reg [7:0] awaddr,
   output reg wvalid,
   input wire wready,
   output reg [31:0] wdata,
   output reg [3:0] wstrb,
   input wire bvalid,
   output reg bready,
   input wire [1:0] bresp,
   // read side
   output reg arvalid,
   input wire arready,
   output reg [7:0] araddr,
   input wire rvalid,
   output reg rready,
   input wire [31:0] rdata,
   input wire [1:0] rresp
);
   reg tmo;
   // idle bus at time zero
   initial
   begin
      {awvalid, wvalid, bready, arvalid, rready, tmo} = 6'h00;
      {awaddr, araddr, wdata, wstrb} = 52'h0;
   end
   // one item per write; bready trails bvalid
   task wr(input [7:0] a, input [31:0] d, output [1:0] resp);
      integer n;
      reg pa, pw;
      begin
         @(posedge ref_clk);
         awvalid <= 1'b1;
         awaddr <= a;
         wvalid <= 1'b1;
         wdata <= d;
         wstrb <= 4'hF;
         pa = 1'b1;
         pw = 1'b1;
         n = 0;
         while ((pa || pw || bvalid !== 1'b1 || !bready) && n < 500)
         begin
            @(posedge ref_clk);
            n = n + 1;
            if (pa && awready === 1'b1)
            begin
               pa = 1'b0;
               awvalid <= 1'b0;
            end
            if (pw && wready === 1'b1)
            begin
               pw = 1'b0;
               wvalid <= 1'b0;
            end
            bready <= bvalid === 1'b1 && !bready;
         end
         resp = bresp;
         if (n >= 500) tmo = 1'b1;
      end
   endtask
   // query; rready trails rvalid
   task rd(input [7:0] a, output [31:0] d, output [1:0] resp);
      integer n;
      reg pa;
      begin
         @(posedge ref_clk);
         arvalid <= 1'b1;
         araddr <= a;
         pa = 1'b1;
         n = 0;
         while ((pa || rvalid !== 1'b1 || !rready) && n < 500)
         begin
            @(posedge ref_clk);
            n = n + 1;
            if (pa && arready === 1'b1)
            begin
               pa = 1'b0;
               arvalid <= 1'b0;
            end
            rready <= rvalid === 1'b1 && !rready;
         end
         d = rdata;
         resp = rresp;
         if (n >= 500) tmo = 1'b1;
      end
   endtask
endmodule // lmps_host

// file: bench/lmps_seq_tb.sv
// bench for the list sequencer
`timescale 1ns/1ns
`include "lmps_regs.vh"
module lmps_seq_tb;
   localparam [31:0] F0 = 32'h00001000;
   localparam [31:0] F1 = 32'h00002000;
   localparam [31:0] F2 = 32'h00003000;
   reg ref_clk;
   reg reset_n = 1'b0;
   wire awv, awr, wv, wr_, bv, br, arv, arr, rv, rr;
   wire [7:0] awa, ara;
   wire [31:0] wd, rdd;
   wire [3:0] ws;
   wire [1:0] bresp, rresp;
   wire [31:0] out_freq;
   wire [15:0] out_power;
   wire sync_out, list_mode, run_busy;
   integer fail_count = 0;
   integer check_count = 0;
   integer i;
   integer cyc = 0;
   reg last_sync = 1'b0;
   logic [31:0] pq[$];
   logic [31:0] eq[$];
   integer tq[$];
   // *****
   // design and host
   // *****
   lmps_seq DUT (.ref_clk(ref_clk), .reset_n(reset_n),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
      .s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wr_),
      .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_bvalid(bv),
      .s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
      .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdd),
      .s_axi_rresp(rresp), .out_freq(out_freq), .out_power(out_power),
      .sync_out(sync_out), .list_mode(list_mode), .run_busy(run_busy));
   lmps_host host (.ref_clk(ref_clk), .awvalid(awv), .awready(awr),
      .awaddr(awa), .wvalid(wv), .wready(wr_), .wdata(wd), .wstrb(ws),
      .bvalid(bv), .bready(br), .bresp(bresp), .arvalid(arv),
      .arready(arr), .araddr(ara), .rvalid(rv), .rready(rr),
      .rdata(rdd), .rresp(rresp));
   // clock
   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   // marker rises mark point starts
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      last_sync <= sync_out;
      if (sync_out === 1'b1 && last_sync === 1'b0)
      begin
         pq.push_back(out_freq);
         tq.push_back(cyc);
      end
   end
   // *****
   // tasks
   // *****
   task test_done;
      begin
         if (fail_count == 0 && check_count > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   task chk(input string nm, input logic [31:0] seen, input [31:0] exp);
      begin
         check_count = check_count + 1;
         if (seen !== exp)
         begin
            fail_count = fail_count + 1;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   // a hang ends the run
   task hang(input bit h);
      begin
         if (h)
         begin
            fail_count = fail_count + 1;
            test_done;
         end
      end
   endtask
   task w(input [7:0] a, input [31:0] d);
      logic [1:0] r;
      begin
         host.wr(a, d, r);
         hang(host.tmo);
         chk("bresp", {30'h0, r}, 32'h0);
      end
   endtask
   task r(input [7:0] a, input [31:0] e, input [1:0] er);
      logic [31:0] d;
      logic [1:0] rs;
      begin
         host.rd(a, d, rs);
         hang(host.tmo);
         chk("rdata", d, e);
         chk("rresp", {30'h0, rs}, {30'h0, er});
      end
   endtask
   task wait_idle;
      integer n;
      begin
         n = 0;
         while (run_busy !== 1'b0 && n < 3000)
         begin
            @(posedge ref_clk);
            n = n + 1;
         end
         hang(n >= 3000);
      end
   endtask
   function [31:0] ctl(input d, input [1:0] rp, input [1:0] sy);
      ctl = {26'h0, sy, rp, 1'b0, d};
   endfunction
   // one run, marked points against eq
   task run(input [31:0] c);
      begin
         w(`LMPS_OFF_CTRL, c);
         pq.delete();
         tq.delete();
         w(`LMPS_OFF_CMD, 32'h1);
         wait_idle;
         chk("points", pq.size(), eq.size());
         for (i = 0; i < eq.size(); i = i + 1)
            chk("point", pq[i], eq[i]);
      end
   endtask
   // *****
   // main sequence
   // *****
   initial
   begin
      repeat (16) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      r(`LMPS_OFF_CTRL, 32'h0, `LMPS_RESP_OKAY);
      r(`LMPS_OFF_AUTO, 32'h1, `LMPS_RESP_OKAY);
      r(8'h40, 32'h0, `LMPS_RESP_SLVERR);
      chk("list_mode", list_mode, 32'h0);
      w(`LMPS_OFF_DWELL, 32'h2);
      w(`LMPS_OFF_DWELL, 32'h5);
      r(`LMPS_OFF_DWELL, 32'h2, `LMPS_RESP_OKAY);
      r(`LMPS_OFF_DWELL_CNT, 32'h2, `LMPS_RESP_OKAY);
      w(`LMPS_OFF_FREQ, F0);
      w(`LMPS_OFF_FREQ, F1);
      w(`LMPS_OFF_FREQ, F2);
      for (i = 0; i < 3; i = i + 1)
         w(`LMPS_OFF_POWER, 32'h10 + i);
      w(`LMPS_OFF_SEQ, 32'h2);
      w(`LMPS_OFF_SEQ, 32'h0);
      r(`LMPS_OFF_FREQ_CNT, 32'h3, `LMPS_RESP_OKAY);
      r(`LMPS_OFF_POWER_CNT, 32'h3, `LMPS_RESP_OKAY);
      r(`LMPS_OFF_SEQ_CNT, 32'h2, `LMPS_RESP_OKAY);
      r(`LMPS_OFF_CONVERT, 32'h0, `LMPS_RESP_OKAY);
      w(`LMPS_OFF_AUTO, 32'h1);
      chk("list_mode", list_mode, 32'h1);
      for (i = 0; i < 3; i = i + 1)
      begin
         w(`LMPS_OFF_CTRL, ctl(1'b0, i, `LMPS_SYNC_NONE));
         r(`LMPS_OFF_CTRL, ctl(1'b0, i, `LMPS_SYNC_NONE), 2'h0);
      end
      eq = '{F0, F1, F2};
      run(ctl(1'b0, `LMPS_REP_SWEEP, `LMPS_SYNC_ALL));
      chk("dwell", tq[1] - tq[0], 2 * `LMPS_DWELL_CYC + 4);
      chk("power", out_power, 32'h12);
      eq = '{F2, F1, F0};
      run(ctl(1'b1, `LMPS_REP_SWEEP, `LMPS_SYNC_ALL));
      eq = '{F0};
      run(ctl(1'b0, `LMPS_REP_SWEEP, `LMPS_SYNC_FIRST));
      run(ctl(1'b1, `LMPS_REP_SWEEP, `LMPS_SYNC_LAST));
      eq.delete();
      run(ctl(1'b0, `LMPS_REP_SWEEP, `LMPS_SYNC_NONE));
      w(`LMPS_OFF_AUTO, 32'h0);
      eq = '{F2, F0};
      run(ctl(1'b0, `LMPS_REP_SWEEP, `LMPS_SYNC_ALL));
      w(`LMPS_OFF_AUTO, 32'h1);
      eq = '{F0};
      run(ctl(1'b0, `LMPS_REP_STEP, `LMPS_SYNC_ALL));
      eq = '{F1};
      run(ctl(1'b0, `LMPS_REP_STEP, `LMPS_SYNC_ALL));
      // continuous wraps until aborted
      w(`LMPS_OFF_CTRL, ctl(1'b0, `LMPS_REP_CONT, `LMPS_SYNC_ALL));
      pq.delete();
      w(`LMPS_OFF_CMD, 32'h1);
      repeat (200) @(posedge ref_clk);
      chk("busy", run_busy, 32'h1);
      chk("wrapped", pq.size() >= 6, 32'h1);
      w(`LMPS_OFF_CMD, 32'h8);
      wait_idle;
      w(`LMPS_OFF_CMD, 32'h10);
      chk("list_mode", list_mode, 32'h0);
      w(`LMPS_OFF_CMD, 32'h2);
      r(`LMPS_OFF_DWELL_CNT, 32'h0, `LMPS_RESP_OKAY);
      test_done;
   end
endmodule // lmps_seq_tb
